// >>> core/sdh_pkg.sv
// Summary of operation
// - Command index error is flagged when a response index mismatches the expected command.
// - An error flag can only set while its status-enable bit is one.
// - The interrupt from a flag is raised only while its signal-enable bit is one.
// - Flags read 0 for no error, 1 for error; writing one clears a flag.
// - Data timeout flags busy, post-token busy, token or read data timeouts.
// - Data CRC error flags bad read CRC or a write token other than 010.
// - Data end bit error flags a 0 end bit on read data or token.
// - Overcurrent after power request cuts card power and flags current limit after sampling.
// - Capabilities are preset and change only while the capability write enable is one.
// - Capability bits 0, 1, 2 report 50 SDR, 104 SDR, 50 DDR support.
// - Capability bits 4, 5, 6 report driver types A, C, D support.
// - Retune timer count field: 0 disables, else period two to field minus one seconds.
// - Tuning-for-50 capability bit says single-rate 50 mode needs tuning.
// - Read-only retuning event register holds one bit per slot.
package sdh_pkg;

  // ==========================================================================
  // Register map.
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_ERR_STATUS  = 8'h00;
  localparam logic [7:0]  OFS_ERR_STEN    = 8'h04;
  localparam logic [7:0]  OFS_ERR_SIGEN   = 8'h08;
  localparam logic [7:0]  OFS_POWER_CTRL  = 8'h0c;
  localparam logic [7:0]  OFS_CAP_CTRL    = 8'h10;
  localparam logic [7:0]  OFS_CAPS_ONE    = 8'h14;
  localparam logic [7:0]  OFS_RETUNE_SLOT = 8'h18;

  // ==========================================================================
  // Shared error bit layout.
  localparam int          NUM_ERR         = 5;
  localparam int          ERR_CMD_INDEX   = 0;
  localparam int          ERR_DATA_TMO    = 1;
  localparam int          ERR_DATA_CRC    = 2;
  localparam int          ERR_DATA_END    = 3;
  localparam int          ERR_CUR_LIMIT   = 4;
  localparam int          NUM_LINK_ERR    = 4;

  // ==========================================================================
  // Control bits and capability layout.
  localparam int          PWR_BUS_REQ_BIT = 0;
  localparam int          CAP_WREN_BIT    = 0;
  localparam int          CAP_SDR50_BIT   = 0;
  localparam int          CAP_SDR104_BIT  = 1;
  localparam int          CAP_DDR50_BIT   = 2;
  localparam int          CAP_DRVA_BIT    = 4;
  localparam int          CAP_DRVC_BIT    = 5;
  localparam int          CAP_DRVD_BIT    = 6;
  localparam int          CAP_RTCNT_LSB   = 8;
  localparam int          CAP_RTCNT_W     = 4;
  localparam int          CAP_TUNE50_BIT  = 13;
  localparam int          CAP_RETUNE_MODE_LSB = 14;
  localparam logic [31:0] CAP_RESET       = 32'h0000_2177;
  localparam logic [31:0] CAP_WMASK       = 32'h00ff_ef77;
  localparam int          NUM_SLOTS       = 2;
  localparam int          SLOT_REG_W      = 8;

  // ==========================================================================
  // Link token and timing.
  localparam logic [2:0]  CRC_TOKEN_OK    = 3'b010;
  localparam int          CMD_INDEX_W     = 6;
  localparam int          PCLK_PERIOD_NS  = 100;
  localparam int          LIMIT_SAMPLE_NS  = 1000;
  localparam int          LIMIT_SAMPLE_CYC = (LIMIT_SAMPLE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int          LIMIT_CNT_W      = 4;

endpackage

// >>> core/sdh_sync.sv
`timescale 1ns/10ps
// ============================================================================
// Two-stage level synchroniser; the first stage feeds only the second.
module sdh_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// >>> core/sdh_err_flag.sv
`timescale 1ns/10ps
// ============================================================================
// One sticky error flag with status-enable gating and write-one clear.
module sdh_err_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic event_in,
  input  wire logic status_en,
  input  wire logic clear,
  output logic      flag_q
);
  logic flag_d;

  always_comb
  begin
    // Enable gates setting. A flag whose enable is off is held at zero.
    // Write-one clear; a coincident event wins over the clear.
    flag_d = status_en & (event_in | (flag_q & ~clear));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    event_in && status_en |=> flag_q)
    else $error("flag did not set on enabled event");
  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag_q && status_en && !clear |=> flag_q)
    else $error("flag dropped without a clear");
endmodule

// >>> core/sdh_error_caps.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sdh_error_caps
  import sdh_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sd_clk,
  input  wire logic                   resp_done,
  input  wire logic [CMD_INDEX_W-1:0] resp_index,
  input  wire logic [CMD_INDEX_W-1:0] expected_index,
  input  wire logic                   busy_resp_timeout,
  input  wire logic                   busy_after_token_timeout,
  input  wire logic                   crc_token_timeout,
  input  wire logic                   read_data_timeout,
  input  wire logic                   read_crc_bad,
  input  wire logic                   read_end_valid,
  input  wire logic                   read_end_bit,
  input  wire logic                   token_valid,
  input  wire logic [2:0]             token_value,
  input  wire logic                   token_end_bit,
  input  wire logic                   overcurrent,
  input  wire logic [NUM_SLOTS-1:0]   retune_event_in,
  output logic                        card_power_en,
  output logic                        err_irq
);

  // ==========================================================================
  // Link domain: error detection on the card clock.
  logic [NUM_LINK_ERR-1:0] link_ev;
  logic [NUM_LINK_ERR-1:0] link_tog_d;
  logic [NUM_LINK_ERR-1:0] link_tog_q;

  always_comb
  begin
    link_ev = '0;
    link_ev[ERR_CMD_INDEX] = resp_done & (resp_index != expected_index);
    link_ev[ERR_DATA_TMO]  = busy_resp_timeout | busy_after_token_timeout | crc_token_timeout | read_data_timeout;
    link_ev[ERR_DATA_CRC]  = read_crc_bad | (token_valid & (token_value != CRC_TOKEN_OK));
    link_ev[ERR_DATA_END]  = (read_end_valid & ~read_end_bit) | (token_valid & ~token_end_bit);
    // Each event flips a toggle so that a single card-clock pulse survives the crossing.
    link_tog_d = link_tog_q ^ link_ev;
  end

  always_ff @(posedge sd_clk or negedge presetn)
  begin
    if (!presetn)
      link_tog_q <= '0;
    else
      link_tog_q <= link_tog_d;
  end

  cmd_match_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    !(resp_done && resp_index != expected_index) |=> $stable(link_tog_q[ERR_CMD_INDEX]))
    else $error("index error without a mismatch");
  busy_tmo_ev_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    busy_resp_timeout || busy_after_token_timeout |=> !$stable(link_tog_q[ERR_DATA_TMO]))
    else $error("busy timeout not detected");
  read_crc_ev_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    read_crc_bad |=> !$stable(link_tog_q[ERR_DATA_CRC]))
    else $error("read crc error missed");
  token_end_ev_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    token_valid && !token_end_bit |=> !$stable(link_tog_q[ERR_DATA_END]))
    else $error("token end bit error missed");

  // ==========================================================================
  // Crossings into the register clock.
  // Two pulses on one source closer than about one register clock cancel in the toggle; the link
  // never repeats one error that fast, so the cheap toggle crossing was chosen over a handshake.
  logic [NUM_LINK_ERR-1:0] tog_sync;
  logic [NUM_LINK_ERR-1:0] tog_seen_q;
  logic [NUM_LINK_ERR-1:0] tog_seen_d;
  logic [NUM_SLOTS:0]      pin_sync;
  logic                    ovc_s;
  logic [NUM_SLOTS-1:0]    slots_s;

  sdh_sync #(.W(NUM_LINK_ERR)) u_tog_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (link_tog_q),
    .dout  (tog_sync)
  );

  sdh_sync #(.W(NUM_SLOTS + 1)) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({retune_event_in, overcurrent}),
    .dout  (pin_sync)
  );

  assign ovc_s   = pin_sync[0];
  assign slots_s = pin_sync[NUM_SLOTS:1];

  always_comb
  begin
    tog_seen_d = tog_sync;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tog_seen_q <= '0;
    else
      tog_seen_q <= tog_seen_d;
  end

  // ==========================================================================
  // APB decode.
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic addr_hit;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en     = access_ph & pwrite;
  // Every register answers from flops or simple muxes, so no access needs a wait state.
  assign pready    = 1'b1;

  always_comb
  begin
    case (paddr)
      OFS_ERR_STATUS, OFS_ERR_STEN, OFS_ERR_SIGEN, OFS_POWER_CTRL,
      OFS_CAP_CTRL, OFS_CAPS_ONE, OFS_RETUNE_SLOT: addr_hit = 1'b1;
      default:                                     addr_hit = 1'b0;
    endcase
  end

  assign pslverr = access_ph & ~addr_hit;

  // ==========================================================================
  // Control registers and current limit supervision.
  logic [NUM_ERR-1:0]      sten_q;
  logic [NUM_ERR-1:0]      sten_d;
  logic [NUM_ERR-1:0]      sigen_q;
  logic [NUM_ERR-1:0]      sigen_d;
  logic                    bus_power_q;
  logic                    bus_power_d;
  logic                    cap_we_q;
  logic                    cap_we_d;
  logic [31:0]             caps_q;
  logic [31:0]             caps_d;
  logic [LIMIT_CNT_W-1:0]  lim_cnt_q;
  logic [LIMIT_CNT_W-1:0]  lim_cnt_d;
  logic                    lim_hit;
  logic [NUM_ERR-1:0]      err_ev;
  logic [NUM_ERR-1:0]      err_clr;
  logic [NUM_ERR-1:0]      flags;

  always_comb
  begin
    sten_d      = sten_q;
    sigen_d     = sigen_q;
    bus_power_d = bus_power_q;
    cap_we_d    = cap_we_q;
    caps_d      = caps_q;
    lim_cnt_d   = '0;
    lim_hit     = 1'b0;
    if (wr_en && paddr == OFS_ERR_STEN)
      sten_d = pwdata[NUM_ERR-1:0];
    if (wr_en && paddr == OFS_ERR_SIGEN)
      sigen_d = pwdata[NUM_ERR-1:0];
    if (wr_en && paddr == OFS_CAP_CTRL)
      cap_we_d = pwdata[CAP_WREN_BIT];
    // Capability preset changes only under write enable.
    if (wr_en && paddr == OFS_CAPS_ONE && cap_we_q)
      caps_d = pwdata & CAP_WMASK;
    if (wr_en && paddr == OFS_POWER_CTRL)
      bus_power_d = pwdata[PWR_BUS_REQ_BIT];
    // Filtered overcurrent cuts power.
    // The filter rides out short inrush spikes; the cut overrides a coincident software write.
    if (bus_power_q && ovc_s)
    begin
      if (lim_cnt_q == LIMIT_CNT_W'(LIMIT_SAMPLE_CYC - 1))
      begin
        lim_hit     = 1'b1;
        bus_power_d = 1'b0;
      end
      else
        lim_cnt_d = lim_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sten_q      <= '0;
      sigen_q     <= '0;
      bus_power_q <= 1'b0;
      cap_we_q    <= 1'b0;
      caps_q      <= CAP_RESET;
      lim_cnt_q   <= '0;
    end
    else
    begin
      sten_q      <= sten_d;
      sigen_q     <= sigen_d;
      bus_power_q <= bus_power_d;
      cap_we_q    <= cap_we_d;
      caps_q      <= caps_d;
      lim_cnt_q   <= lim_cnt_d;
    end
  end

  assign card_power_en = bus_power_q;

  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && !addr_hit |=> sten_q == $past(sten_q) && sigen_q == $past(sigen_q)
      && cap_we_q == $past(cap_we_q) && caps_q == $past(caps_q))
    else $error("unmapped write changed a register");
  power_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_POWER_CTRL && !lim_hit |=> bus_power_q == $past(pwdata[PWR_BUS_REQ_BIT]))
    else $error("power request write lost");
  power_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_power_q && !ovc_s && !(wr_en && paddr == OFS_POWER_CTRL) |=> bus_power_q)
    else $error("power cut without overcurrent");
  caps_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_CAPS_ONE && cap_we_q |=> caps_q == ($past(pwdata) & CAP_WMASK))
    else $error("open capability write lost");
  caps_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cap_we_q |=> $stable(caps_q))
    else $error("capabilities moved while locked");
  limit_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags[ERR_CUR_LIMIT]) |-> $past(ovc_s) && $past(bus_power_q) && !bus_power_q)
    else $error("current limit flag without overcurrent");

  // ==========================================================================
  // Error flags.
  always_comb
  begin
    err_ev                          = '0;
    err_ev[NUM_LINK_ERR-1:0]        = tog_sync ^ tog_seen_q;
    err_ev[ERR_CUR_LIMIT]           = lim_hit;
    err_clr = (wr_en && paddr == OFS_ERR_STATUS) ? pwdata[NUM_ERR-1:0] : '0;
  end

  // A write of one clears a flag; an event in the same cycle keeps it set.
  // Same bit index across flag and both enables.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ERR; gi++)
    begin : g_flag
      sdh_err_flag u_flag (
        .pclk      (pclk),
        .presetn   (presetn),
        .event_in  (err_ev[gi]),
        .status_en (sten_q[gi]),
        .clear     (err_clr[gi]),
        .flag_q    (flags[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Interrupt output.
  // Signal enable gates the interrupt.
  assign err_irq = |(flags & sigen_q);

  // ==========================================================================
  // Read data, captured in the setup cycle.
  // Capturing early keeps prdata on a flop and still lets every access finish in one cycle.
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      OFS_ERR_STATUS:  rd_mux[NUM_ERR-1:0] = flags;
      OFS_ERR_STEN:    rd_mux[NUM_ERR-1:0] = sten_q;
      OFS_ERR_SIGEN:   rd_mux[NUM_ERR-1:0] = sigen_q;
      OFS_POWER_CTRL:  rd_mux[PWR_BUS_REQ_BIT] = bus_power_q;
      OFS_CAP_CTRL:    rd_mux[CAP_WREN_BIT] = cap_we_q;
      OFS_CAPS_ONE:    rd_mux = caps_q;
      OFS_RETUNE_SLOT: rd_mux[NUM_SLOTS-1:0] = slots_s;
      default:         rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (setup_ph && !pwrite)
      prdata_q <= rd_mux;
  end

  assign prdata = prdata_q;

  rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(setup_ph && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");

  // ==========================================================================
  // Checks.
  cmd_index_ev_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    resp_done && resp_index != expected_index |=> link_tog_q[ERR_CMD_INDEX] != $past(link_tog_q[ERR_CMD_INDEX]))
    else $error("index mismatch not detected");
  timeout_ev_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    read_data_timeout || crc_token_timeout |=> link_tog_q[ERR_DATA_TMO] != $past(link_tog_q[ERR_DATA_TMO]))
    else $error("timeout not detected");
  token_crc_ev_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    !read_crc_bad && token_valid |=> (link_tog_q[ERR_DATA_CRC] != $past(link_tog_q[ERR_DATA_CRC]))
      == ($past(token_value) != CRC_TOKEN_OK))
    else $error("token crc check wrong");
  end_bit_ev_a: assert property (@(posedge sd_clk) disable iff (!presetn)
    read_end_valid && !read_end_bit |=> link_tog_q[ERR_DATA_END] != $past(link_tog_q[ERR_DATA_END]))
    else $error("end bit error missed");
  stat_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (flags & ~$past(sten_q)) == '0)
    else $error("flag set while disabled");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_irq |-> (flags & sigen_q & $past(sten_q)) != '0)
    else $error("interrupt without enabled flag");
  w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_ERR_STATUS |=> (flags & $past(pwdata[NUM_ERR-1:0]) & ~$past(err_ev)) == '0)
    else $error("write one did not clear");
  limit_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_power_q && ovc_s && lim_cnt_q == LIMIT_CNT_W'(LIMIT_SAMPLE_CYC - 1) && sten_q[ERR_CUR_LIMIT]
      |=> !bus_power_q && flags[ERR_CUR_LIMIT])
    else $error("current limit did not cut power");
  cap_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_CAPS_ONE && !cap_we_q |=> caps_q == $past(caps_q))
    else $error("capabilities changed while locked");
  slot_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && paddr == OFS_RETUNE_SLOT |=> prdata[NUM_SLOTS-1:0] == $past(slots_s)
      && prdata[31:NUM_SLOTS] == '0)
    else $error("slot register read wrong");

endmodule

// >>> verif/sdh_card_model.sv
`timescale 1ns/10ps
// ============================================================================
// Card side of the link: each call of send puts one event on the link for one sd_clk cycle.
module sdh_card_model
  import sdh_pkg::*;
(
  input  wire logic                   sd_clk,
  output logic                        resp_done,
  output logic [CMD_INDEX_W-1:0]      resp_index,
  output logic [CMD_INDEX_W-1:0]      expected_index,
  output logic                        busy_resp_timeout,
  output logic                        busy_after_token_timeout,
  output logic                        crc_token_timeout,
  output logic                        read_data_timeout,
  output logic                        read_crc_bad,
  output logic                        read_end_valid,
  output logic                        read_end_bit,
  output logic                        token_valid,
  output logic [2:0]                  token_value,
  output logic                        token_end_bit
);
  logic busy;

  initial
  begin
    busy = 1'b0;
    {resp_done, busy_resp_timeout, busy_after_token_timeout, crc_token_timeout} = 4'h0;
    {read_data_timeout, read_crc_bad, read_end_valid, token_valid} = 4'h0;
  end

  // Qualifiers carry no meaning between events, so they wander instead of holding the last value.
  always @(posedge sd_clk)
  begin
    if (!busy)
    begin
      {resp_index, expected_index, token_value} <= 15'($urandom);
      {read_end_bit, token_end_bit} <= 2'($urandom);
    end
  end

  // Kinds: 0 index mismatch, 1 index match, 2..5 timeouts, 6 read crc, 7 bad token, 8 good token,
  // 9 read end bit low, 10 read end bit high, 11 token end bit low.
  task automatic send(input int k);
    logic [CMD_INDEX_W-1:0] ix;
    ix = CMD_INDEX_W'($urandom);
    // Raised before the edge so that the wandering process leaves this event's qualifiers alone.
    busy = 1'b1;
    @(posedge sd_clk);
    resp_done <= (k < 2);
    expected_index <= ix;
    resp_index <= (k == 0) ? ~ix : ix;
    busy_resp_timeout <= (k == 2);
    busy_after_token_timeout <= (k == 3);
    crc_token_timeout <= (k == 4);
    read_data_timeout <= (k == 5);
    read_crc_bad <= (k == 6);
    read_end_valid <= (k == 9) || (k == 10);
    read_end_bit <= (k == 10);
    token_valid <= (k == 7) || (k == 8) || (k == 11);
    token_value <= (k == 7) ? (CRC_TOKEN_OK ^ 3'($urandom_range(1, 7))) : CRC_TOKEN_OK;
    token_end_bit <= (k != 11);
    @(posedge sd_clk);
    {resp_done, busy_resp_timeout, busy_after_token_timeout, crc_token_timeout} <= 4'h0;
    {read_data_timeout, read_crc_bad, read_end_valid, token_valid} <= 4'h0;
    busy <= 1'b0;
  endtask
endmodule

// >>> verif/sdh_error_caps_test.sv
`timescale 1ns/10ps
module sdh_error_caps_test
  import sdh_pkg::*;
;
  logic                   pclk = 1'b0;
  logic                   sd_clk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [ADDR_W-1:0]      paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   overcurrent = 1'b0;
  logic [NUM_SLOTS-1:0]   retune_event_in = 2'h0;
  logic                   card_power_en;
  logic                   err_irq;
  logic                   resp_done, busy_resp_timeout, busy_after_token_timeout, crc_token_timeout;
  logic                   read_data_timeout, read_crc_bad, read_end_valid, read_end_bit;
  logic                   token_valid, token_end_bit;
  logic [2:0]             token_value;
  logic [CMD_INDEX_W-1:0] resp_index, expected_index;
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  int                     cyc = 0;
  logic [31:0]            rdv, rnd;
  logic                   err;
  logic [4:0]             sten, sigen, e;
  int                     k;

  sdh_error_caps dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sd_clk(sd_clk),
    .resp_done(resp_done), .resp_index(resp_index), .expected_index(expected_index),
    .busy_resp_timeout(busy_resp_timeout), .busy_after_token_timeout(busy_after_token_timeout),
    .crc_token_timeout(crc_token_timeout), .read_data_timeout(read_data_timeout), .read_crc_bad(read_crc_bad),
    .read_end_valid(read_end_valid), .read_end_bit(read_end_bit), .token_valid(token_valid),
    .token_value(token_value), .token_end_bit(token_end_bit), .overcurrent(overcurrent),
    .retune_event_in(retune_event_in), .card_power_en(card_power_en), .err_irq(err_irq));

  sdh_card_model card (.sd_clk(sd_clk), .resp_done(resp_done), .resp_index(resp_index),
    .expected_index(expected_index), .busy_resp_timeout(busy_resp_timeout),
    .busy_after_token_timeout(busy_after_token_timeout), .crc_token_timeout(crc_token_timeout),
    .read_data_timeout(read_data_timeout), .read_crc_bad(read_crc_bad), .read_end_valid(read_end_valid),
    .read_end_bit(read_end_bit), .token_valid(token_valid), .token_value(token_value),
    .token_end_bit(token_end_bit));

  // ==========================================================================
  // Clocks and watchdog.
  initial forever #50 pclk = ~pclk;
  initial
  begin
    #2.3;
    forever #3 sd_clk = ~sd_clk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request is held until pready is seen high; no wait count is assumed.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rdv);
    check("pslverr", 32'h0, {31'h0, err});
  endtask

  function automatic logic [4:0] exp_flags(input int kind);
    case (kind)
      0: exp_flags = 5'(1 << ERR_CMD_INDEX);
      2, 3, 4, 5: exp_flags = 5'(1 << ERR_DATA_TMO);
      6, 7: exp_flags = 5'(1 << ERR_DATA_CRC);
      9, 11: exp_flags = 5'(1 << ERR_DATA_END);
      default: exp_flags = 5'h00;
    endcase
  endfunction

  // ==========================================================================
  // Main sequence.
  initial
  begin
    void'($urandom(32472));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check("power_reset", 32'h0, {31'h0, card_power_en});
    rd_chk("caps_reset", OFS_CAPS_ONE, 32'h0000_2177);
    rd_chk("status_reset", OFS_ERR_STATUS, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    check("unmapped_data", 32'h0, rdv);
    rnd = $urandom;
    apb(1'b1, OFS_CAPS_ONE, rnd);
    rd_chk("caps_locked", OFS_CAPS_ONE, 32'h0000_2177);
    apb(1'b1, OFS_CAP_CTRL, 32'h1);
    apb(1'b1, OFS_CAPS_ONE, rnd);
    rd_chk("caps_open", OFS_CAPS_ONE, rnd & CAP_WMASK);
    apb(1'b1, OFS_CAP_CTRL, 32'h0);
    apb(1'b1, OFS_CAPS_ONE, ~rnd);
    rd_chk("caps_relocked", OFS_CAPS_ONE, rnd & CAP_WMASK);
    for (int i = 0; i < 36; i++)
    begin
      k = (i < 12) ? i : $urandom_range(0, 11);
      sten = (i < 12) ? 5'h1f : 5'($urandom);
      sigen = (i < 12) ? 5'h00 : 5'($urandom);
      apb(1'b1, OFS_ERR_STEN, {27'h0, sten});
      apb(1'b1, OFS_ERR_SIGEN, {27'h0, sigen});
      card.send(k);
      repeat (8) @(posedge pclk);
      e = exp_flags(k) & sten;
      rd_chk("status_event", OFS_ERR_STATUS, {27'h0, e});
      check("irq_event", {31'h0, |(e & sigen)}, {31'h0, err_irq});
      apb(1'b1, OFS_ERR_STATUS, 32'h1f);
      rd_chk("status_cleared", OFS_ERR_STATUS, 32'h0);
      check("irq_cleared", 32'h0, {31'h0, err_irq});
    end
    apb(1'b1, OFS_ERR_STEN, 32'h1f);
    apb(1'b1, OFS_ERR_SIGEN, 32'h10);
    apb(1'b1, OFS_POWER_CTRL, 32'h1);
    @(posedge pclk);
    check("power_on", 32'h1, {31'h0, card_power_en});
    overcurrent <= 1'b1;
    repeat (4) @(posedge pclk);
    overcurrent <= 1'b0;
    repeat (16) @(posedge pclk);
    check("power_glitch", 32'h1, {31'h0, card_power_en});
    overcurrent <= 1'b1;
    repeat (16) @(posedge pclk);
    check("power_cut", 32'h0, {31'h0, card_power_en});
    rd_chk("limit_flag", OFS_ERR_STATUS, 32'h10);
    check("limit_irq", 32'h1, {31'h0, err_irq});
    overcurrent <= 1'b0;
    apb(1'b1, OFS_ERR_STATUS, 32'h10);
    rd_chk("limit_cleared", OFS_ERR_STATUS, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = {30'h0, 2'(i)};
      retune_event_in <= rnd[1:0];
      repeat (4) @(posedge pclk);
      rd_chk("retune_slots", OFS_RETUNE_SLOT, rnd);
    end
    end_sim();
  end
endmodule
